/* wfs_params.svh */
`ifndef WFS_PARAMS_SVH
`define WFS_PARAMS_SVH
`define WFS_ADDR_W 7
`define WFS_DATA_W 8
`define WFS_OFS_LIN_PORT_TWO_FAULT_CODE 7'h45
`define WFS_OFS_WAKE_A 7'h46
`define WFS_OFS_WAKE_B 7'h47
`define WFS_OFS_LEVEL 7'h48
`define WFS_OFS_HS_OVL 7'h54
`define WFS_OFS_HS_OL 7'h55
`define WFS_ZERO_BYTE 8'h00
`define WFS_MASK_FAIL 8'h06
`define WFS_MASK_WAKE_A 8'hF7
`define WFS_MASK_WAKE_B 8'h30
`define WFS_MASK_HS 8'h0F
`define WFS_RESTART_FAIL 8'h06
`define WFS_RESTART_WAKE_A 8'hF7
`define WFS_RESTART_WAKE_B 8'h30
`define WFS_RESTART_HS 8'h0F
`define WFS_FAIL_HI 2
`define WFS_FAIL_LO 1
`define WFS_WAKEA_PIN_LO 0
`define WFS_WAKEA_PIN_HI 2
`define WFS_WAKEA_TIMER 4
`define WFS_WAKEA_CAN 5
`define WFS_WAKEA_LIN1 6
`define WFS_WAKEA_LIN2 7
`define WFS_WAKEB_GP_LO 4
`define WFS_WAKEB_GP_HI 5
`define WFS_HS_LO 0
`define WFS_HS_HI 3
`define WFS_LVL_WAKE_LO 0
`define WFS_LVL_WAKE_HI 2
`define WFS_LVL_RSVD 3
`define WFS_LVL_GP_LO 4
`define WFS_LVL_PULLUP 6
`define WFS_LVL_DEV 7
`define WFS_CODE_NONE 2'h0
`define WFS_CODE_THERMAL 2'h1
`define WFS_CODE_TX_STUCK 2'h2
`define WFS_CODE_BUS_STUCK 2'h3
`define WFS_STUCK_TIME_MS 20
`define WFS_CLK_MHZ 200
`define WFS_TX_EN_TIME_NS 10000
`define WFS_TX_EN_CYCLES ((`WFS_TX_EN_TIME_NS * `WFS_CLK_MHZ + 999) / 1000)
`define WFS_CNT_W 16
`endif

/* wfs_pkg.sv */
package wfs_pkg;
	typedef enum logic [1:0] {
		wfs_mode_normal = 2'h0,
		wfs_mode_stop = 2'h1,
		wfs_mode_sleep = 2'h2,
		wfs_mode_fail_safe = 2'h3
	} wfs_op_mode_t;
	typedef enum logic [2:0] {
		wfs_gp_off = 3'h0,
		wfs_gp_wake = 3'h1,
		wfs_gp_low_side = 3'h2,
		wfs_gp_high_side = 3'h3,
		wfs_gp_gpio = 3'h4
	} wfs_gp_cfg_t;
	typedef enum logic [2:0] {
		wfs_tx_on = 3'h1,
		wfs_tx_fault = 3'h2,
		wfs_tx_wait = 3'h4
	} wfs_tx_state_t;
	typedef logic [1:0] wfs_fault_code_t;
endpackage

/* wfs_lvl_if.sv */
`timescale 1ns/10ps
interface wfs_lvl_if import wfs_pkg::*; ();
	logic clk;
	logic reset;
	logic soft_reset;
	wfs_op_mode_t op_mode;
	logic cyclic_sense;
	logic sample_strobe;
	logic [2:0] wake_pin_raw;
	logic [1:0] gp_raw;
	wfs_gp_cfg_t gp_one_cfg;
	wfs_gp_cfg_t gp_two_cfg;
	logic dev_strap;
	logic pullup_strap;
	logic [7:0] level_byte;
	modport owner (output clk, reset, soft_reset, op_mode, cyclic_sense,
		sample_strobe, wake_pin_raw, gp_raw, gp_one_cfg, gp_two_cfg,
		dev_strap, pullup_strap, input level_byte);
	modport tracker (input clk, reset, soft_reset, op_mode, cyclic_sense,
		sample_strobe, wake_pin_raw, gp_raw, gp_one_cfg, gp_two_cfg,
		dev_strap, pullup_strap, output level_byte);
endinterface

/* wfs_level_track.sv */
`timescale 1ns/10ps
`include "wfs_params.svh"
module wfs_level_track import wfs_pkg::*; (
	wfs_lvl_if.tracker lv
);
	logic [2:0] wake_lvl_q;
	logic [1:0] gp_lvl_q;
	logic dev_q;
	logic pullup_q;
	logic active_mode;
	wfs_gp_cfg_t gp_cfg [2];

	assign active_mode = (lv.op_mode == wfs_mode_normal) ||
		(lv.op_mode == wfs_mode_stop);
	assign gp_cfg[0] = lv.gp_one_cfg;
	assign gp_cfg[1] = lv.gp_two_cfg;

	// Straps follow the pins while reset is held
	always_ff @(posedge lv.clk) begin
		if (lv.reset || lv.soft_reset) begin
			dev_q <= lv.dev_strap;
			pullup_q <= lv.pullup_strap;
		end
	end

	// Cyclic sense only refreshes on the sampling strobe
	always_ff @(posedge lv.clk) begin
		if (lv.reset || lv.soft_reset) begin
			wake_lvl_q <= lv.wake_pin_raw;
		end else if (!lv.cyclic_sense || lv.sample_strobe) begin
			wake_lvl_q <= lv.wake_pin_raw;
		end
	end

	// No strobe here: these pins cannot be cyclically sensed
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_gp
			always_ff @(posedge lv.clk) begin
				if (lv.reset || lv.soft_reset) begin
					gp_lvl_q[gi] <= 1'b0;
				end else if (active_mode && gp_cfg[gi] != wfs_gp_off) begin
					gp_lvl_q[gi] <= lv.gp_raw[gi];
				end
			end
		end
	endgenerate

	always_comb begin
		lv.level_byte = `WFS_ZERO_BYTE;
		lv.level_byte[`WFS_LVL_DEV] = dev_q;
		lv.level_byte[`WFS_LVL_PULLUP] = pullup_q;
		lv.level_byte[`WFS_LVL_GP_LO +: 2] = gp_lvl_q;
		lv.level_byte[`WFS_LVL_RSVD] = 1'b0;
		lv.level_byte[`WFS_LVL_WAKE_HI:`WFS_LVL_WAKE_LO] = wake_lvl_q;
	end
endmodule

/* wfs_status_regs.sv */
`timescale 1ns/10ps
`include "wfs_params.svh"
// Notes on behaviour
// - Fault code field: none, thermal, tx stuck, bus stuck
// - Reserved bits always read zero
// - Tx stuck ends: txd high, wake-capable, off
// - Bus stuck ends: recessive, wake-capable, off
// - Undervoltage ends when supply above threshold
// - Transmit re-enabled after txd high enable time
// - Wake register A: lin2,lin1,can,timer,pins
// - Fail-safe wakes also set source flags
// - Bit seven shows development mode strap
// - Bit six shows interrupt pin pull-up
// - Gp levels update in normal, stop modes
// - Cyclic sense holds latest sampled level
// - Gp levels never follow cyclic sampling
// - Gp level shown even as switch
// - Overload flags for four high-side switches
// - Overload flags may spuriously set at low battery
// - Open-load flags for four high-side switches
// - Restart keeps fault code and every flag
// - Restart keeps all wake A and wake B bits
// - Restart keeps low four switch flags
// - Reset or soft reset zeroes fault, wake and switch registers
// - Reset clears gp level bits, straps follow
module wfs_status_regs import wfs_pkg::*; #(
	parameter int TX_EN_CYCLES = `WFS_TX_EN_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic restart,
	input wire logic acc_read,
	input wire logic acc_write,
	input wire logic [`WFS_ADDR_W-1:0] acc_addr,
	output logic [`WFS_DATA_W-1:0] acc_rdata,
	output logic acc_rdata_valid,
	input wire logic lin_port_two_txd,
	input wire logic lin_port_two_bus_recessive,
	input wire logic lin_port_two_wake_capable,
	input wire logic lin_port_two_off,
	input wire logic thermal_shutdown,
	input wire logic lin_port_two_tx_stuck,
	input wire logic lin_port_two_bus_stuck,
	input wire logic high_side_supply_uv,
	input wire logic high_side_supply_above_threshold,
	output logic lin_port_two_tx_enable,
	output logic [1:0] lin_port_two_fault_code,
	input wire logic wake_from_lin_port_two,
	input wire logic wake_from_lin_port_one,
	input wire logic wake_from_can_bus,
	input wire logic wake_from_timer,
	input wire logic wake_from_pin_three,
	input wire logic wake_from_pin_two,
	input wire logic wake_from_pin_one,
	input wire logic wake_from_gp_pin_two,
	input wire logic wake_from_gp_pin_one,
	input wire logic [3:0] switch_overload,
	input wire logic [3:0] switch_open_load,
	input wire wfs_op_mode_t op_mode,
	input wire logic cyclic_sense,
	input wire logic sample_strobe,
	input wire logic [2:0] wake_pin_level_raw,
	input wire logic [1:0] gp_pin_level_raw,
	input wire wfs_gp_cfg_t gp_pin_one_cfg,
	input wire wfs_gp_cfg_t gp_pin_two_cfg,
	input wire logic fail_output_test_pin,
	input wire logic int_pin_pullup_sense
);
	// Counter width bounds the enable time
	if (TX_EN_CYCLES < 1 || TX_EN_CYCLES >= (1 << `WFS_CNT_W)) begin : g_bad
		$error("TX_EN_CYCLES out of range");
	end

	localparam logic [`WFS_CNT_W-1:0] TX_EN_LAST =
		`WFS_CNT_W'(TX_EN_CYCLES - 1);

	wfs_lvl_if lvl ();

	logic clr_fail;
	logic clr_wake_a;
	logic clr_wake_b;
	logic clr_ovl;
	logic clr_ol;
	logic wipe;
	logic tx_stuck_q;
	logic bus_stuck_q;
	logic uv_q;
	logic thermal_prev_q;
	logic any_fault;
	wfs_fault_code_t new_code;
	wfs_fault_code_t code_q;
	wfs_tx_state_t tx_state_q;
	logic [`WFS_CNT_W-1:0] txd_high_cnt_q;
	logic [7:0] wake_a_set;
	logic [7:0] wake_b_set;
	logic [7:0] wake_a_q;
	logic [7:0] wake_b_q;
	logic [7:0] ovl_q;
	logic [7:0] ol_q;
	logic [7:0] rdata_q;
	logic rvalid_q;

	assign wipe = reset || soft_reset;

	// Writes clear; reads never do, so a lost read loses no event
	assign clr_fail = acc_write && acc_addr == `WFS_OFS_LIN_PORT_TWO_FAULT_CODE;
	assign clr_wake_a = acc_write && acc_addr == `WFS_OFS_WAKE_A;
	assign clr_wake_b = acc_write && acc_addr == `WFS_OFS_WAKE_B;
	assign clr_ovl = acc_write && acc_addr == `WFS_OFS_HS_OVL;
	assign clr_ol = acc_write && acc_addr == `WFS_OFS_HS_OL;

	// Sticky update: new sets win over a same-cycle clear
	function automatic logic [7:0] sticky(input logic [7:0] q,
		input logic [7:0] set, input logic clr, input logic rst,
		input logic [7:0] keep, input logic [7:0] valid);
		logic [7:0] held;
		held = clr ? `WFS_ZERO_BYTE : q;
		if (rst) begin
			held = held & keep;
		end
		sticky = (held | set) & valid;
	endfunction

	// Fault conditions and their ending conditions
	always_ff @(posedge clk) begin
		if (wipe) begin
			tx_stuck_q <= 1'b0;
		end else if (lin_port_two_tx_stuck) begin
			tx_stuck_q <= 1'b1;
		end else if (lin_port_two_txd || lin_port_two_wake_capable ||
			lin_port_two_off) begin
			tx_stuck_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (wipe) begin
			bus_stuck_q <= 1'b0;
		end else if (lin_port_two_bus_stuck) begin
			bus_stuck_q <= 1'b1;
		end else if (lin_port_two_bus_recessive ||
			lin_port_two_wake_capable || lin_port_two_off) begin
			bus_stuck_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (wipe) begin
			uv_q <= 1'b0;
		end else if (high_side_supply_uv) begin
			uv_q <= 1'b1;
		end else if (high_side_supply_above_threshold) begin
			uv_q <= 1'b0;
		end
	end

	assign any_fault = tx_stuck_q || bus_stuck_q || uv_q || thermal_shutdown;

	// Transmit gate: wait out faults, then txd high for enable time
	always_ff @(posedge clk) begin
		if (wipe) begin
			tx_state_q <= wfs_tx_on;
			txd_high_cnt_q <= '0;
		end else begin
			case (tx_state_q)
				wfs_tx_on: begin
					if (any_fault) begin
						tx_state_q <= wfs_tx_fault;
					end
				end
				wfs_tx_fault: begin
					txd_high_cnt_q <= '0;
					if (!any_fault) begin
						tx_state_q <= wfs_tx_wait;
					end
				end
				wfs_tx_wait: begin
					if (any_fault) begin
						tx_state_q <= wfs_tx_fault;
						txd_high_cnt_q <= '0;
					end else if (!lin_port_two_txd) begin
						txd_high_cnt_q <= '0;
					end else if (txd_high_cnt_q == TX_EN_LAST) begin
						tx_state_q <= wfs_tx_on;
						txd_high_cnt_q <= '0;
					end else begin
						txd_high_cnt_q <= txd_high_cnt_q + 1'b1;
					end
				end
				default: begin
					tx_state_q <= wfs_tx_fault;
					txd_high_cnt_q <= '0;
				end
			endcase
		end
	end

	assign lin_port_two_tx_enable = tx_state_q == wfs_tx_on;

	always_ff @(posedge clk) begin
		if (wipe) begin
			thermal_prev_q <= 1'b0;
		end else begin
			thermal_prev_q <= thermal_shutdown;
		end
	end

	// Thermal outranks bus, bus outranks txd
	always_comb begin
		new_code = `WFS_CODE_NONE;
		if (thermal_shutdown && !thermal_prev_q) begin
			new_code = `WFS_CODE_THERMAL;
		end else if (lin_port_two_bus_stuck) begin
			new_code = `WFS_CODE_BUS_STUCK;
		end else if (lin_port_two_tx_stuck) begin
			new_code = `WFS_CODE_TX_STUCK;
		end
	end

	// First failure is kept until cleared
	always_ff @(posedge clk) begin
		if (wipe) begin
			code_q <= `WFS_CODE_NONE;
		end else if (new_code != `WFS_CODE_NONE &&
			(clr_fail || code_q == `WFS_CODE_NONE)) begin
			code_q <= new_code;
		end else if (clr_fail) begin
			code_q <= `WFS_CODE_NONE;
		end
	end

	assign lin_port_two_fault_code = code_q;

	// Fail-safe wakes arrive on the same source strobes
	always_comb begin
		wake_a_set = `WFS_ZERO_BYTE;
		wake_a_set[`WFS_WAKEA_LIN2] = wake_from_lin_port_two;
		wake_a_set[`WFS_WAKEA_LIN1] = wake_from_lin_port_one;
		wake_a_set[`WFS_WAKEA_CAN] = wake_from_can_bus;
		wake_a_set[`WFS_WAKEA_TIMER] = wake_from_timer;
		wake_a_set[`WFS_WAKEA_PIN_HI:`WFS_WAKEA_PIN_LO] = {wake_from_pin_three,
			wake_from_pin_two, wake_from_pin_one};
		wake_b_set = `WFS_ZERO_BYTE;
		wake_b_set[`WFS_WAKEB_GP_HI] = wake_from_gp_pin_two;
		wake_b_set[`WFS_WAKEB_GP_LO] = wake_from_gp_pin_one;
	end

	always_ff @(posedge clk) begin
		if (wipe) begin
			wake_a_q <= `WFS_ZERO_BYTE;
		end else begin
			wake_a_q <= sticky(wake_a_q, wake_a_set, clr_wake_a, restart,
				`WFS_RESTART_WAKE_A, `WFS_MASK_WAKE_A);
		end
	end

	always_ff @(posedge clk) begin
		if (wipe) begin
			wake_b_q <= `WFS_ZERO_BYTE;
		end else begin
			wake_b_q <= sticky(wake_b_q, wake_b_set, clr_wake_b, restart,
				`WFS_RESTART_WAKE_B, `WFS_MASK_WAKE_B);
		end
	end

	// Spurious sets near low battery are not filtered; host decides
	always_ff @(posedge clk) begin
		if (wipe) begin
			ovl_q <= `WFS_ZERO_BYTE;
		end else begin
			ovl_q <= sticky(ovl_q, {4'h0, switch_overload}, clr_ovl, restart,
				`WFS_RESTART_HS, `WFS_MASK_HS);
		end
	end

	always_ff @(posedge clk) begin
		if (wipe) begin
			ol_q <= `WFS_ZERO_BYTE;
		end else begin
			ol_q <= sticky(ol_q, {4'h0, switch_open_load}, clr_ol, restart,
				`WFS_RESTART_HS, `WFS_MASK_HS);
		end
	end

	assign lvl.clk = clk;
	assign lvl.reset = reset;
	assign lvl.soft_reset = soft_reset;
	assign lvl.op_mode = op_mode;
	assign lvl.cyclic_sense = cyclic_sense;
	assign lvl.sample_strobe = sample_strobe;
	assign lvl.wake_pin_raw = wake_pin_level_raw;
	assign lvl.gp_raw = gp_pin_level_raw;
	assign lvl.gp_one_cfg = gp_pin_one_cfg;
	assign lvl.gp_two_cfg = gp_pin_two_cfg;
	assign lvl.dev_strap = fail_output_test_pin;
	assign lvl.pullup_strap = int_pin_pullup_sense;

	wfs_level_track u_level (
		.lv(lvl.tracker)
	);

	// Read data registered; unmapped offsets answer zero
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= `WFS_ZERO_BYTE;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= acc_read;
			if (acc_read) begin
				case (acc_addr)
					`WFS_OFS_LIN_PORT_TWO_FAULT_CODE: begin
						rdata_q <= {5'h00, code_q, 1'b0};
					end
					`WFS_OFS_WAKE_A: begin
						rdata_q <= wake_a_q;
					end
					`WFS_OFS_WAKE_B: begin
						rdata_q <= wake_b_q;
					end
					`WFS_OFS_LEVEL: begin
						rdata_q <= lvl.level_byte;
					end
					`WFS_OFS_HS_OVL: begin
						rdata_q <= ovl_q;
					end
					`WFS_OFS_HS_OL: begin
						rdata_q <= ol_q;
					end
					default: begin
						rdata_q <= `WFS_ZERO_BYTE;
					end
				endcase
			end
		end
	end

	assign acc_rdata = rdata_q;
	assign acc_rdata_valid = rvalid_q;
endmodule

/* wfs_status_regs_monitor.sv */
`timescale 1ns/10ps
`include "wfs_params.svh"
module wfs_status_regs_monitor import wfs_pkg::*; #(
	parameter int TX_EN_CYCLES = `WFS_TX_EN_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic soft_reset,
	input wire logic acc_read,
	input wire logic [`WFS_ADDR_W-1:0] acc_addr,
	input wire logic [`WFS_DATA_W-1:0] acc_rdata,
	input wire logic acc_rdata_valid,
	input wire logic thermal_shutdown,
	input wire logic lin_port_two_txd,
	input wire logic lin_port_two_tx_enable,
	input wire logic [1:0] lin_port_two_fault_code
);
	logic [15:0] txd_run_q;
	default clocking @(posedge clk); endclocking
	default disable iff (reset || soft_reset);
	// Saturates, so a long idle line never wraps to zero
	always_ff @(posedge clk) begin
		if (reset || !lin_port_two_txd) begin
			txd_run_q <= 16'h0000;
		end else if (txd_run_q != 16'hFFFF) begin
			txd_run_q <= txd_run_q + 16'h0001;
		end
	end
	sequence s_rd(a);
		acc_read && acc_addr == a;
	endsequence
	sequence s_heat_up;
		!thermal_shutdown ##1
		thermal_shutdown && lin_port_two_fault_code == 2'h0;
	endsequence
	a_read_answers: assert property (acc_read |=> acc_rdata_valid)
		else $error("read not answered next cycle");
	a_no_stray_valid: assert property (!acc_read |=> !acc_rdata_valid)
		else $error("read data valid without a read");
	a_fail_rsvd_zero: assert property (s_rd(`WFS_OFS_LIN_PORT_TWO_FAULT_CODE) |=>
		(acc_rdata & 8'hF9) == 8'h00) else $error("fault byte spare bits set");
	a_fail_code_read: assert property (s_rd(`WFS_OFS_LIN_PORT_TWO_FAULT_CODE) |=>
		acc_rdata[2:1] == $past(lin_port_two_fault_code))
		else $error("fault field differs from fault code");
	a_wake_a_rsvd: assert property (s_rd(`WFS_OFS_WAKE_A) |=>
		!acc_rdata[3]) else $error("wake A spare bit set");
	a_wake_b_rsvd: assert property (s_rd(`WFS_OFS_WAKE_B) |=>
		(acc_rdata & 8'hCF) == 8'h00) else $error("wake B spare bits set");
	a_hs_upper_zero: assert property (s_rd(`WFS_OFS_HS_OVL) or
		s_rd(`WFS_OFS_HS_OL) |=> acc_rdata[7:4] == 4'h0)
		else $error("switch byte upper bits set");
	a_lvl_rsvd: assert property (s_rd(`WFS_OFS_LEVEL) |=>
		!acc_rdata[3]) else $error("level spare bit set");
	a_heat_code: assert property (s_heat_up |=>
		lin_port_two_fault_code == `WFS_CODE_THERMAL)
		else $error("thermal code not loaded");
	a_heat_stops_tx: assert property (lin_port_two_tx_enable &&
		thermal_shutdown |=> !lin_port_two_tx_enable)
		else $error("transmitter kept on while hot");
	a_tx_held_back: assert property ($rose(lin_port_two_tx_enable) |->
		txd_run_q >= TX_EN_CYCLES) else $error("transmitter back too early");
endmodule
bind wfs_status_regs wfs_status_regs_monitor #(.TX_EN_CYCLES(TX_EN_CYCLES))
	i_wfs_status_regs_monitor (.*);

/* wfs_host_model.sv */
`timescale 1ns/10ps
`include "wfs_params.svh"
module wfs_host_model (
	input wire logic clk,
	output logic acc_read,
	output logic acc_write,
	output logic [`WFS_ADDR_W-1:0] acc_addr,
	input wire logic [`WFS_DATA_W-1:0] acc_rdata,
	input wire logic acc_rdata_valid
);
	initial begin
		{acc_read, acc_write} = 2'h0;
		acc_addr = 7'h7F;
	end
	// Write clears flags once handled; idle address shows its inverse
	task automatic xfer(input logic wr, input logic [6:0] a,
		output logic [7:0] d, output logic v);
		@(posedge clk);
		#1;
		{acc_write, acc_read} = {wr, !wr};
		acc_addr = a;
		@(posedge clk);
		#1;
		{acc_write, acc_read} = 2'h0;
		acc_addr = ~a;
		d = acc_rdata;
		v = acc_rdata_valid;
	endtask
endmodule

/* wfs_status_regs_tb_top.sv */
`timescale 1ns/10ps
`include "wfs_params.svh"
module wfs_status_regs_tb_top import wfs_pkg::*; ;
	logic clk, reset, soft_reset, restart, acc_read, acc_write;
	logic [6:0] acc_addr;
	logic [7:0] acc_rdata, d;
	logic acc_rdata_valid, lin_port_two_tx_enable, v;
	logic [1:0] lin_port_two_fault_code, gp_pin_level_raw, g;
	logic lin_port_two_txd, lin_port_two_bus_recessive, thermal_shutdown;
	logic lin_port_two_wake_capable, lin_port_two_off;
	logic lin_port_two_tx_stuck, lin_port_two_bus_stuck;
	logic high_side_supply_uv, high_side_supply_above_threshold;
	logic wake_from_lin_port_two, wake_from_lin_port_one, wake_from_can_bus;
	logic wake_from_timer, wake_from_pin_three, wake_from_pin_two;
	logic wake_from_pin_one, wake_from_gp_pin_two, wake_from_gp_pin_one;
	logic [3:0] switch_overload, switch_open_load, ov, ol;
	wfs_op_mode_t op_mode;
	logic cyclic_sense, sample_strobe, fail_output_test_pin;
	logic int_pin_pullup_sense;
	logic [2:0] wake_pin_level_raw, lw;
	wfs_gp_cfg_t gp_pin_one_cfg, gp_pin_two_cfg;
	logic [8:0] wk, w;
	logic [6:0] regs [6] = '{`WFS_OFS_LIN_PORT_TWO_FAULT_CODE, `WFS_OFS_WAKE_A,
		`WFS_OFS_WAKE_B, `WFS_OFS_HS_OVL, `WFS_OFS_HS_OL, 7'h50};
	int seed = 32'ha11b;
	int n_mismatch = 0;
	int n_checks = 0;
	// Strap levels latched at the last reset
	logic [1:0] st = 2'h2;
	assign {wake_from_lin_port_two, wake_from_lin_port_one, wake_from_can_bus,
		wake_from_timer, wake_from_pin_three, wake_from_pin_two,
		wake_from_pin_one, wake_from_gp_pin_two, wake_from_gp_pin_one} = wk;
	// Short enable count keeps the recovery scenarios brief
	wfs_status_regs #(.TX_EN_CYCLES(4)) i_wfs_status_regs (.*);
	wfs_host_model i_wfs_host_model (.*);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		i_wfs_host_model.xfer(1'b0, a, d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [7:0] lvl(input logic [1:0] gp,
		input logic [2:0] wp);
		return {st, gp, 1'b0, wp};
	endfunction
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Roughly thirty-five times the expected run
	initial begin
		#60000;
		n_mismatch++;
		results;
	end
	initial begin
		{soft_reset, restart, thermal_shutdown, lin_port_two_off} = 4'h0;
		{lin_port_two_wake_capable, lin_port_two_tx_stuck} = 2'h0;
		{lin_port_two_bus_stuck, high_side_supply_uv, cyclic_sense} = 3'h0;
		{wk, switch_overload, switch_open_load, sample_strobe} = '0;
		{lin_port_two_txd, lin_port_two_bus_recessive} = 2'h3;
		{high_side_supply_above_threshold, fail_output_test_pin} = 2'h3;
		int_pin_pullup_sense = 1'b0;
		op_mode = wfs_mode_normal;
		{gp_pin_one_cfg, gp_pin_two_cfg} = {wfs_gp_off, wfs_gp_off};
		{wake_pin_level_raw, gp_pin_level_raw} = 5'h16;
		reset = 1'b1;
		step(10);
		reset = 1'b0;
		{lw, g} = 5'h14;
		foreach (regs[i]) rdc(regs[i], 8'h00);
		rdc(`WFS_OFS_LEVEL, lvl(g, lw));
		for (int k = 0; k < 5; k++) begin
			op_mode = wfs_op_mode_t'(k[1:0]);
			w = (k == 0) ? 9'h1FF : 9'($random(seed));
			ov = 4'($random(seed));
			ol = 4'($random(seed));
			{wk, switch_overload, switch_open_load} = {w, ov, ol};
			step(1);
			{wk, switch_overload, switch_open_load} = '0;
			restart = 1'b1;
			step(1);
			restart = 1'b0;
			rdc(`WFS_OFS_WAKE_A, {w[8:5], 1'b0, w[4:2]});
			rdc(`WFS_OFS_WAKE_B, {2'h0, w[1:0], 4'h0});
			rdc(`WFS_OFS_HS_OVL, {4'h0, ov});
			rdc(`WFS_OFS_HS_OL, {4'h0, ol});
			foreach (regs[i]) i_wfs_host_model.xfer(1'b1, regs[i], d, v);
			foreach (regs[i]) rdc(regs[i], 8'h00);
		end
		op_mode = wfs_mode_normal;
		for (int c = 0; c < 4; c++) begin
			case (c)
			0: {high_side_supply_uv, high_side_supply_above_threshold} = 2'h2;
			1: thermal_shutdown = 1'b1;
			2: {lin_port_two_txd, lin_port_two_tx_stuck} = 2'h1;
			default: {lin_port_two_bus_recessive, lin_port_two_bus_stuck} = 2'h1;
			endcase
			step(1);
			{high_side_supply_uv, lin_port_two_tx_stuck} = 2'h0;
			{lin_port_two_bus_stuck, restart} = 2'h1;
			step(1);
			restart = 1'b0;
			chk({7'h00, lin_port_two_tx_enable}, 8'h00);
			rdc(`WFS_OFS_LIN_PORT_TWO_FAULT_CODE, {5'h00, 2'(c), 1'b0});
			case (c)
			0: high_side_supply_above_threshold = 1'b1;
			1: thermal_shutdown = 1'b0;
			2: lin_port_two_off = 1'b1;
			default: lin_port_two_wake_capable = 1'b1;
			endcase
			step(3);
			lin_port_two_txd = 1'b1;
			for (int t = 0; t < 20 && lin_port_two_tx_enable !== 1'b1; t++)
				step(1);
			chk({7'h00, lin_port_two_tx_enable}, 8'h01);
			{lin_port_two_off, lin_port_two_wake_capable} = 2'h0;
			lin_port_two_bus_recessive = 1'b1;
			i_wfs_host_model.xfer(1'b1, `WFS_OFS_LIN_PORT_TWO_FAULT_CODE, d, v);
			rdc(`WFS_OFS_LIN_PORT_TWO_FAULT_CODE, 8'h00);
		end
		for (int k = 0; k < 16; k++) begin
			op_mode = wfs_op_mode_t'(2'($random(seed)));
			{cyclic_sense, sample_strobe} = 2'($random(seed));
			gp_pin_one_cfg = wfs_gp_cfg_t'(3'({$random(seed)} % 5));
			gp_pin_two_cfg = wfs_gp_cfg_t'(3'({$random(seed)} % 5));
			{wake_pin_level_raw, gp_pin_level_raw} = 5'($random(seed));
			if (!cyclic_sense || sample_strobe)
				lw = wake_pin_level_raw;
			if (op_mode < 2 && gp_pin_one_cfg != wfs_gp_off)
				g[0] = gp_pin_level_raw[0];
			if (op_mode < 2 && gp_pin_two_cfg != wfs_gp_off)
				g[1] = gp_pin_level_raw[1];
			step(1);
			sample_strobe = 1'b0;
			step(1);
			rdc(`WFS_OFS_LEVEL, lvl(g, lw));
		end
		op_mode = wfs_mode_sleep;
		{fail_output_test_pin, int_pin_pullup_sense} = 2'h1;
		wk = 9'h001;
		step(1);
		wk = '0;
		soft_reset = 1'b1;
		step(1);
		// Straps moved after reset must not show
		{soft_reset, fail_output_test_pin, int_pin_pullup_sense} = 3'h2;
		st = 2'h1;
		lw = wake_pin_level_raw;
		rdc(`WFS_OFS_WAKE_B, 8'h00);
		rdc(`WFS_OFS_LEVEL, lvl(2'h0, lw));
		results;
	end
endmodule
